// file: src/rpc_map.vh
// constants shared by the counter-command interpreter files
`ifndef RPC_MAP_VH
`define RPC_MAP_VH

// command types carried in the second byte of a frame
`define RPC_CMD_KEY_UPDATE 8'h01
`define RPC_CMD_INCREMENT  8'h02
`define RPC_CMD_REQUEST    8'h03

// frame lengths in link clocks, opcode included
`define RPC_LEN_SHORT 9'h140
`define RPC_LEN_LONG  9'h180
`define RPC_LEN_BYTE  9'h008

// extended status bit positions
`define RPC_ST_BUSY     0
`define RPC_ST_CTR_UNIN 1
`define RPC_ST_BAD      2
`define RPC_ST_KEY_UNIN 3
`define RPC_ST_DATA     4
`define RPC_ST_FATAL    5

// extended status values
`define RPC_ST_POWER_ON 8'h00
`define RPC_ST_SUCCESS  8'h80

// message lengths handed to the hash core
`define RPC_MSG_32  8'h20
`define RPC_MSG_64  8'h40
`define RPC_MSG_128 8'h80

`endif

// file: src/rpc_link_rx.v
// serial link receiver: synchronises pins, shifts in bits, marks frame events
`timescale 1ns/100ps
module rpc_link_rx #(
   parameter SH_W = 384
) (
   // clock and reset
   input  wire            clk_sys,
   input  wire            rst_n,
   // link pins, asynchronous to clk_sys
   input  wire            sclk,
   input  wire            cs_n,
   input  wire            si,
   // received frame
   output reg  [SH_W-1:0] shift_q,
   output reg  [8:0]      bit_cnt_q,
   output reg             first_byte_q,
   output reg             frame_end_q
);
`include "rpc_map.vh"

   reg  sclk_m_q, sclk_s_q, sclk_d_q;
   reg  cs_m_q, cs_s_q, cs_d_q;
   reg  si_m_q, si_s_q;
   wire sclk_rise;

   // the first stage of each synchroniser feeds only its second stage
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sclk_m_q <= 1'b0;
         sclk_s_q <= 1'b0;
         sclk_d_q <= 1'b0;
         cs_m_q   <= 1'b1;
         cs_s_q   <= 1'b1;
         cs_d_q   <= 1'b1;
         si_m_q   <= 1'b0;
         si_s_q   <= 1'b0;
      end else begin
         sclk_m_q <= sclk;
         sclk_s_q <= sclk_m_q;
         sclk_d_q <= sclk_s_q;
         cs_m_q   <= cs_n;
         cs_s_q   <= cs_m_q;
         cs_d_q   <= cs_s_q;
         si_m_q   <= si;
         si_s_q   <= si_m_q;
      end
   end

   // data and clock pass equal delays, so si is taken at its own edge
   assign sclk_rise = sclk_s_q & ~sclk_d_q & ~cs_s_q;

   // shifter and clock counter; the count saturates so long frames stay long
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         shift_q      <= {SH_W{1'b0}};
         bit_cnt_q    <= 9'h000;
         first_byte_q <= 1'b0;
         frame_end_q  <= 1'b0;
      end else begin
         first_byte_q <= sclk_rise & (bit_cnt_q == (`RPC_LEN_BYTE - 9'h001));
         frame_end_q  <= cs_s_q & ~cs_d_q;
         if (cs_d_q && !cs_s_q) begin
            bit_cnt_q <= 9'h000;
         end else if (sclk_rise) begin
            shift_q <= {shift_q[SH_W-2:0], si_s_q};
            if (bit_cnt_q != 9'h1FF) begin
               bit_cnt_q <= bit_cnt_q + 9'h001;
            end
         end
      end
   end
endmodule

// file: src/rpc_key_store.v
// per-counter session keys and monotonic counters, all volatile
`timescale 1ns/100ps
module rpc_key_store #(
   parameter NUM_CTR = 4,
   parameter IDX_W   = 2
) (
   // clock and reset
   input  wire                  clk_sys,
   input  wire                  rst_n,
   // read port
   input  wire [IDX_W-1:0]      idx,
   output wire [255:0]          sess_key,
   output wire                  sess_ok,
   output wire [31:0]           ctr_val,
   output wire                  ctr_ok,
   // updates, all to entry idx
   input  wire                  key_wr,
   input  wire [255:0]          key_in,
   input  wire                  ctr_inc,
   // counter load after reset
   input  wire                  ctr_load,
   input  wire [NUM_CTR*32-1:0] ctr_load_val,
   input  wire [NUM_CTR-1:0]    ctr_load_ok
);

   wire [NUM_CTR*256-1:0] key_flat;
   wire [NUM_CTR*32-1:0]  ctr_flat;
   wire [NUM_CTR-1:0]     key_vld;
   wire [NUM_CTR-1:0]     ctr_vld;

   genvar g;
   generate
      for (g = 0; g < NUM_CTR; g = g + 1) begin : entry
         // entry number cut to the index width on purpose
         localparam [31:0]      ME_WIDE = g;
         localparam [IDX_W-1:0] ME      = ME_WIDE[IDX_W-1:0];
         reg [255:0] key_q;
         reg         key_vld_q;
         reg [31:0]  ctr_q;
         reg         ctr_vld_q;
         // keys are lost at reset and must be derived again
         always @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               key_q     <= 256'h0;
               key_vld_q <= 1'b0;
               ctr_q     <= 32'h0000_0000;
               ctr_vld_q <= 1'b0;
            end else begin
               if (key_wr && idx == ME) begin
                  key_q     <= key_in; // RULE_03
                  key_vld_q <= 1'b1;
               end
               if (ctr_load) begin
                  ctr_q     <= ctr_load_val[g*32 +: 32];
                  ctr_vld_q <= ctr_load_ok[g];
               end else if (ctr_inc && idx == ME && ctr_q != 32'hFFFF_FFFF) begin
                  ctr_q <= ctr_q + 32'h0000_0001; // RULE_11
               end
            end
         end
         assign key_flat[g*256 +: 256] = key_q;
         assign ctr_flat[g*32 +: 32]   = ctr_q;
         assign key_vld[g]             = key_vld_q;
         assign ctr_vld[g]             = ctr_vld_q;
      end
   endgenerate

   // read multiplexers
   assign sess_key = key_flat[idx*256 +: 256];
   assign ctr_val  = ctr_flat[idx*32 +: 32];
   assign sess_ok  = key_vld[idx];
   assign ctr_ok   = ctr_vld[idx];
endmodule

// file: src/rpc_cmd_top.v
// counter command interpreter: key update, increment and counter request
// Summary of operation
// RULE_01: type 01 replaces the addressed session key
// RULE_02: controller repeats key update after power cycle
// RULE_03: session keys are volatile, lost at reset
// RULE_04: derive key: hash key data with root key
// RULE_05: key update signature keyed with derived key
// RULE_06: clean frame executes, status reads 10000000
// RULE_07: any error changes nothing, sets error bit
// RULE_08: bit 0 high while a command executes
// RULE_09: type 01: bit 1 on uninitialized counter
// RULE_10: bit 2: bad length, signature or address
// RULE_11: type 02 success adds exactly one; the code holds a counter that stands at FFFFFFFF and still reports success
// RULE_12: increment data must equal present counter
// RULE_13: increment signature over header and counter data
// RULE_14: types 02/03: bit 3 on uninitialized key/counter
// RULE_15: type 02: bit 4 on counter data mismatch
// RULE_16: type 03 signature over header and tag
// RULE_17: bit 2 on command type out of range
// RULE_18: status and signed counter offered for readback
// RULE_19: status zero after reset; bit 5 fatal
// RULE_20: status holds until eight opcode bits arrive
// RULE_21: fields packed most significant first
`timescale 1ns/100ps
module rpc_cmd_top #(
   parameter       NUM_CTR = 4,
   parameter       IDX_W   = 2,
   parameter [7:0] OPCODE  = 8'hC0
) (
   // clock and reset
   input  wire                   clk_sys,
   input  wire                   rst_n,
   // serial link
   input  wire                   sclk,
   input  wire                   cs_n,
   input  wire                   si,
   // non-volatile contents offered at power-up
   input  wire [NUM_CTR*256-1:0] root_key_flat,
   input  wire [NUM_CTR*32-1:0]  ctr_init_value,
   input  wire [NUM_CTR-1:0]     ctr_init_valid,
   // external hash core
   output reg                    hash_req,
   output reg  [255:0]           hash_key,
   output reg  [127:0]           hash_msg,
   output reg  [7:0]             hash_msg_bits,
   input  wire                   hash_done,
   input  wire [255:0]           hash_digest,
   // status and readback
   output reg  [7:0]             ext_status,
   output reg                    resp_valid,
   output reg  [95:0]            resp_tag,
   output reg  [31:0]            resp_count,
   output reg  [255:0]           resp_sig
);
`include "rpc_map.vh"

   // ***************************************************
   // states
   // ***************************************************
   localparam [2:0] S_IDLE   = 3'h0;
   localparam [2:0] S_CHECK  = 3'h1;
   localparam [2:0] S_DERIVE = 3'h2;
   localparam [2:0] S_SIGN   = 3'h3;
   localparam [2:0] S_ANSWER = 3'h4;

   // ***************************************************
   // declarations
   // ***************************************************
   wire [383:0]     shift;
   wire [8:0]       bit_cnt;
   wire             first_byte;
   wire             frame_end;
   wire [255:0]     sess_key;
   wire             sess_ok;
   wire [31:0]      ctr_val;
   wire             ctr_ok;
   reg  [2:0]       state_q, state_d;
   reg              active_q, active_d;
   reg              loaded_q;
   reg              fatal_q;
   reg  [8:0]       len_q, len_d;
   reg  [31:0]      hdr_q, hdr_d;
   reg  [95:0]      arg_q, arg_d;
   reg  [255:0]     sig_q, sig_d;
   reg  [7:0]       status_d;
   reg              req_d;
   reg  [255:0]     key_d;
   reg  [127:0]     msg_d;
   reg  [7:0]       bits_d;
   reg              resp_valid_d;
   reg  [95:0]      resp_tag_d;
   reg  [31:0]      resp_count_d;
   reg  [255:0]     resp_sig_d;
   reg              key_wr;
   reg              ctr_inc;
   wire [7:0]       cmd;
   wire [7:0]       addr;
   wire             addr_bad;
   wire             len_ok;
   wire [IDX_W-1:0] idx;
   wire [255:0]     root_key;
   wire [7:0]       error_base;

   // ***************************************************
   // submodules
   // ***************************************************
   rpc_link_rx #(
      .SH_W         (384)
   ) u_rx (
      .clk_sys      (clk_sys),
      .rst_n        (rst_n),
      .sclk         (sclk),
      .cs_n         (cs_n),
      .si           (si),
      .shift_q      (shift),
      .bit_cnt_q    (bit_cnt),
      .first_byte_q (first_byte),
      .frame_end_q  (frame_end)
   );

   rpc_key_store #(
      .NUM_CTR      (NUM_CTR),
      .IDX_W        (IDX_W)
   ) u_store (
      .clk_sys      (clk_sys),
      .rst_n        (rst_n),
      .idx          (idx),
      .sess_key     (sess_key),
      .sess_ok      (sess_ok),
      .ctr_val      (ctr_val),
      .ctr_ok       (ctr_ok),
      .key_wr       (key_wr),
      .key_in       (hash_key),
      .ctr_inc      (ctr_inc),
      .ctr_load     (~loaded_q),
      .ctr_load_val (ctr_init_value),
      .ctr_load_ok  (ctr_init_valid)
   );

   // ***************************************************
   // field decode of the latched frame
   // ***************************************************
   assign cmd        = hdr_q[23:16];
   assign addr       = hdr_q[15:8];
   assign idx        = addr[IDX_W-1:0];
   assign root_key   = root_key_flat[idx*256 +: 256];
   // an index past the last counter is refused before any table is read
   assign addr_bad   = ({24'h0, addr} >= NUM_CTR);
   assign error_base = {2'b00, fatal_q, 5'b00000};
   // each type has exactly one legal length; unknown types never match
   assign len_ok = ((cmd == `RPC_CMD_KEY_UPDATE || cmd == `RPC_CMD_INCREMENT) && len_q == `RPC_LEN_SHORT) ||
                   (cmd == `RPC_CMD_REQUEST && len_q == `RPC_LEN_LONG);

   // ***************************************************
   // command sequencer, next values
   // ***************************************************
   always @* begin
      state_d      = state_q;
      active_d     = active_q;
      len_d        = len_q;
      hdr_d        = hdr_q;
      arg_d        = arg_q;
      sig_d        = sig_q;
      status_d     = ext_status;
      req_d        = hash_req;
      key_d        = hash_key;
      msg_d        = hash_msg;
      bits_d       = hash_msg_bits;
      resp_valid_d = resp_valid;
      resp_tag_d   = resp_tag;
      resp_count_d = resp_count;
      resp_sig_d   = resp_sig;
      key_wr       = 1'b0;
      ctr_inc      = 1'b0;
      case (state_q)
         S_IDLE: begin
            // status is untouched until a whole opcode has been seen
            if (first_byte && loaded_q) begin
               active_d = (shift[7:0] == OPCODE); // RULE_20
               if (shift[7:0] == OPCODE) begin
                  status_d     = error_base | 8'h01; // RULE_08
                  resp_valid_d = 1'b0;
               end
            end
            if (frame_end && active_q) begin
               active_d = 1'b0;
               len_d    = bit_cnt;
               sig_d    = shift[255:0];
               // fields arrive first-in-most-significant, so they sit packed
               if (bit_cnt == `RPC_LEN_LONG) begin
                  hdr_d = shift[383:352]; // RULE_21
                  arg_d = shift[351:256];
               end else begin
                  hdr_d = shift[319:288];
                  arg_d = {64'h0, shift[287:256]};
               end
               state_d = S_CHECK;
            end
         end
         S_CHECK: begin
            state_d = S_IDLE;
            if (!len_ok || addr_bad) begin
               status_d = error_base | (8'h01 << `RPC_ST_BAD); // RULE_10 RULE_17 RULE_07
            end else if (cmd == `RPC_CMD_KEY_UPDATE) begin
               if (!ctr_ok) begin
                  status_d = error_base | (8'h01 << `RPC_ST_CTR_UNIN); // RULE_09
               end else begin
                  // first pass: root key over the raw key data
                  req_d   = 1'b1;
                  key_d   = root_key; // RULE_04
                  msg_d   = {96'h0, arg_q[31:0]};
                  bits_d  = `RPC_MSG_32;
                  state_d = S_DERIVE;
               end
            end else if (!sess_ok || !ctr_ok) begin
               status_d = error_base | (8'h01 << `RPC_ST_KEY_UNIN); // RULE_14
            end else begin
               req_d   = 1'b1;
               key_d   = sess_key;
               state_d = S_SIGN;
               if (cmd == `RPC_CMD_INCREMENT) begin
                  msg_d  = {64'h0, hdr_q, arg_q[31:0]}; // RULE_13
                  bits_d = `RPC_MSG_64;
               end else begin
                  msg_d  = {hdr_q, arg_q}; // RULE_16
                  bits_d = `RPC_MSG_128;
               end
            end
         end
         S_DERIVE: begin
            if (hash_done) begin
               // second pass checks the frame under the candidate key
               key_d   = hash_digest; // RULE_05
               msg_d   = {64'h0, hdr_q, arg_q[31:0]};
               bits_d  = `RPC_MSG_64;
               state_d = S_SIGN;
            end
         end
         S_SIGN: begin
            if (hash_done) begin
               req_d   = 1'b0;
               state_d = S_IDLE;
               if (hash_digest != sig_q) begin
                  status_d = error_base | (8'h01 << `RPC_ST_BAD); // RULE_10 RULE_07
               end else if (cmd == `RPC_CMD_KEY_UPDATE) begin
                  key_wr   = 1'b1; // RULE_01
                  status_d = `RPC_ST_SUCCESS; // RULE_06
               end else if (cmd == `RPC_CMD_INCREMENT) begin
                  if (arg_q[31:0] != ctr_val) begin
                     status_d = error_base | (8'h01 << `RPC_ST_DATA); // RULE_15 RULE_12
                  end else begin
                     ctr_inc  = 1'b1; // RULE_11
                     status_d = `RPC_ST_SUCCESS; // RULE_06
                  end
               end else begin
                  // sign the answer before busy drops, so readback is whole
                  req_d        = 1'b1;
                  key_d        = sess_key;
                  msg_d        = {arg_q, ctr_val};
                  bits_d       = `RPC_MSG_128;
                  resp_tag_d   = arg_q;
                  resp_count_d = ctr_val;
                  state_d      = S_ANSWER;
               end
            end
         end
         S_ANSWER: begin
            if (hash_done) begin
               req_d        = 1'b0;
               resp_sig_d   = hash_digest;
               resp_valid_d = 1'b1; // RULE_18
               status_d     = `RPC_ST_SUCCESS; // RULE_06
               state_d      = S_IDLE;
            end
         end
         default: begin
            state_d = S_IDLE;
            req_d   = 1'b0;
         end
      endcase
   end

   // ***************************************************
   // registers
   // ***************************************************
   // volatile state starts clean; counters load one cycle after release
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q       <= S_IDLE;
         active_q      <= 1'b0;
         loaded_q      <= 1'b0;
         fatal_q       <= 1'b0;
         len_q         <= 9'h000;
         hdr_q         <= 32'h0000_0000;
         arg_q         <= 96'h0;
         sig_q         <= 256'h0;
         ext_status    <= `RPC_ST_POWER_ON; // RULE_19
         hash_req      <= 1'b0;
         hash_key      <= 256'h0;
         hash_msg      <= 128'h0;
         hash_msg_bits <= 8'h00;
         resp_valid    <= 1'b0;
         resp_tag      <= 96'h0;
         resp_count    <= 32'h0000_0000;
         resp_sig      <= 256'h0;
      end else begin
         loaded_q <= 1'b1;
         if (!loaded_q) begin
            // no usable counter at all is fatal and stays reported
            fatal_q    <= ~|ctr_init_valid; // RULE_19
            ext_status <= {2'b00, ~|ctr_init_valid, 5'b00000};
         end else begin
            ext_status <= status_d;
         end
         state_q       <= state_d;
         active_q      <= active_d;
         len_q         <= len_d;
         hdr_q         <= hdr_d;
         arg_q         <= arg_d;
         sig_q         <= sig_d;
         hash_req      <= req_d;
         hash_key      <= key_d;
         hash_msg      <= msg_d;
         hash_msg_bits <= bits_d;
         resp_valid    <= resp_valid_d;
         resp_tag      <= resp_tag_d;
         resp_count    <= resp_count_d;
         resp_sig      <= resp_sig_d;
      end
   end
endmodule

// file: dv/rpc_cmd_assertions.sv
// concurrent checks on the counter command interpreter ports
`timescale 1ns/100ps
module rpc_cmd_assertions #(
   parameter       NUM_CTR = 4,
   parameter       IDX_W   = 2,
   parameter [7:0] OPCODE  = 8'hC0
) (
   // clock, reset and framing
   input wire         clk_sys,
   input wire         rst_n,
   input wire         cs_n,
   // hash core
   input wire         hash_req,
   input wire [255:0] hash_key,
   input wire [127:0] hash_msg,
   input wire [7:0]   hash_msg_bits,
   input wire         hash_done,
   input wire [255:0] hash_digest,
   // status and readback
   input wire [7:0]   ext_status,
   input wire         resp_valid,
   input wire [255:0] resp_sig
);
   // ****************************************
   // properties, all in the system clock domain
   // ****************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   property p_ok_code;
      ext_status[7] |-> ext_status == 8'h80;
   endproperty
   a_ok_code: assert property (p_ok_code) else $error("success code carries extra bits");

   property p_busy_code;
      $rose(ext_status[0]) |-> (ext_status & 8'hDF) == 8'h01;
   endproperty
   a_busy_code: assert property (p_busy_code) else $error("busy code wrong at opcode byte");

   property p_busy_hash;
      hash_req |-> ext_status[0];
   endproperty
   a_busy_hash: assert property (p_busy_hash) else $error("hashing while not busy");

   property p_req_hold;
      hash_req && !hash_done |=> hash_req && $stable(hash_key) && $stable(hash_msg) && $stable(hash_msg_bits);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("hash request moved before answer");

   property p_req_end;
      hash_done && hash_req |=> !hash_req || !$stable(hash_key) || !$stable(hash_msg);
   endproperty
   a_req_end: assert property (p_req_end) else $error("hash request repeated unchanged");

   property p_msg_len;
      hash_req |-> hash_msg_bits inside {8'h20, 8'h40, 8'h80};
   endproperty
   a_msg_len: assert property (p_msg_len) else $error("illegal hash message length");

   property p_msg_align;
      hash_req && hash_msg_bits != 8'h80 |-> hash_msg[127:64] == 64'h0;
   endproperty
   a_msg_align: assert property (p_msg_align) else $error("short message not right aligned");

   property p_idle_hold;
      !ext_status[0] && cs_n && $past(rst_n) |=> $stable(ext_status);
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("status moved with link idle");

   property p_done_code;
      $fell(ext_status[0]) |-> ext_status[7:1] != 7'h00;
   endproperty
   a_done_code: assert property (p_done_code) else $error("busy cleared without result");

   property p_sig_out;
      $rose(resp_valid) |-> resp_sig == hash_digest && ext_status == 8'h80;
   endproperty
   a_sig_out: assert property (p_sig_out) else $error("readback signature not from hash");

   // main scenarios reached
   c_success: cover property (ext_status == 8'h80);
   c_derive: cover property (hash_done && hash_msg_bits == 8'h20);
   c_readback: cover property ($rose(resp_valid));
endmodule

// file: dv/rpc_ctl_model.sv
// behavioural flash controller: frames bits onto the serial link
`timescale 1ns/100ps
module rpc_ctl_model #(
   parameter HALF = 400
) (
   output logic sclk,
   output logic cs_n,
   output logic si
);
   // link idles deselected with the clock parked low
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si   = 1'b0;
   end

   // one frame, most significant bit first; clock stands still outside frames
   task automatic send(input logic [383:0] frm, input int n);
      cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         si = frm[i];
         #HALF sclk = 1'b1;
         #HALF sclk = 1'b0;
      end
      #HALF cs_n = 1'b1;
      si = ~si; // no pull on the line, so a released wire must not look held
   endtask
endmodule

// file: dv/testbench.sv
// self-checking bench for the counter command interpreter
`timescale 1ns/100ps
module testbench;
   localparam       NUM_CTR = 4;
   localparam       IDX_W   = 2;
   localparam [7:0] OPC     = 8'hC0;
   localparam [31:0] KD     = 32'h5EED_0001;
   localparam [95:0] TAG    = 96'hFACE_0000_1234_5678_9ABC;
   logic                   clk_sys = 1'b0;
   logic                   rst_n   = 1'b0;
   wire                    sclk, cs_n, si, hash_req, resp_valid;
   wire  [255:0]           hash_key, resp_sig;
   wire  [127:0]           hash_msg;
   wire  [7:0]             hash_msg_bits, ext_status;
   wire  [95:0]            resp_tag;
   wire  [31:0]            resp_count;
   logic [NUM_CTR*256-1:0] root_key_flat  = {256'h44, 256'h33, 256'h22, 256'h11} ^ {16{64'h0F1E_2D3C_4B5A_6978}};
   logic [NUM_CTR*32-1:0]  ctr_init_value = {32'h0000_0400, 32'h0000_0300, 32'h0000_0200, 32'h0000_0100};
   logic [NUM_CTR-1:0]     ctr_init_valid = 4'h7;
   logic                   hash_done      = 1'b0;
   logic [255:0]           hash_digest    = 256'h0;
   int                     hc_cnt = 0, hc_lim = 2, errors = 0, tests_run = 0;
   logic [255:0]           s0;

   always #50 clk_sys = ~clk_sys;

   rpc_ctl_model ctl (.sclk(sclk), .cs_n(cs_n), .si(si));

   rpc_cmd_top #(.NUM_CTR(NUM_CTR), .IDX_W(IDX_W), .OPCODE(OPC)) dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si),
      .root_key_flat(root_key_flat), .ctr_init_value(ctr_init_value), .ctr_init_valid(ctr_init_valid),
      .hash_req(hash_req), .hash_key(hash_key), .hash_msg(hash_msg), .hash_msg_bits(hash_msg_bits),
      .hash_done(hash_done), .hash_digest(hash_digest), .ext_status(ext_status), .resp_valid(resp_valid),
      .resp_tag(resp_tag), .resp_count(resp_count), .resp_sig(resp_sig));

   // ****************************************
   // helpers
   // ****************************************
   // stand-in keyed mix; cheap, but any field slip changes it
   function automatic logic [255:0] fh(input logic [255:0] k, input logic [127:0] m, input logic [7:0] b);
      fh = {k[127:0], k[255:128]} ^ {m, m} ^ {248'h0, b};
   endfunction

   // hash stand-in: answers after 2 or 5 cycles in turn, digest held until the next answer
   always @(posedge clk_sys) begin
      #1;
      hash_done <= 1'b0;
      if (hash_req && !hash_done) begin
         if (hc_cnt >= hc_lim) begin
            hash_done   <= 1'b1;
            hash_digest <= fh(hash_key, hash_msg, hash_msg_bits);
            hc_cnt      <= 0;
            hc_lim      <= 7 - hc_lim;
         end else begin
            hc_cnt <= hc_cnt + 1;
         end
      end
   end

   task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic do_reset;
      @(posedge clk_sys);
      #1 rst_n = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask

   // one command frame signed with key k, cut bits dropped from the tail, then wait for the result
   task automatic op(input logic [7:0] t, input logic [7:0] a, input logic [95:0] pl, input logic [255:0] k,
                     input int cut, input logic [7:0] exp);
      logic [127:0] msg;
      logic [383:0] frm;
      msg = (t == 8'h03) ? {OPC, t, a, 8'h00, pl} : {64'h0, OPC, t, a, 8'h00, pl[31:0]};
      frm = (t == 8'h03) ? {msg, fh(k, msg, 8'h80)} : {64'h0, msg[63:0], fh(k, msg, 8'h40)};
      ctl.send(frm >> cut, ((t == 8'h03) ? 384 : 320) - cut);
      @(posedge clk_sys);
      #1 chk(ext_status[0], 1'b1);
      // look just after the edge so the busy bit is read settled, never in the launching step
      for (int i = 0; i < 400 && ext_status[0]; i++) begin
         @(posedge clk_sys);
         #1;
      end
      chk(ext_status, exp);
   endtask

   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      s0 = fh(root_key_flat[255:0], {96'h0, KD}, 8'h20);
      do_reset();
      chk(ext_status, 8'h00);
      op(8'h02, 8'h00, 96'h100, s0, 0, 8'h08);
      op(8'h03, 8'h01, TAG, s0, 0, 8'h08);
      op(8'h01, 8'h00, KD, s0, 0, 8'h80);
      op(8'h01, 8'h03, KD, s0, 0, 8'h02);
      op(8'h02, 8'h00, 96'h100, s0, 0, 8'h80);
      op(8'h02, 8'h00, 96'h100, s0, 0, 8'h10);
      op(8'h02, 8'h00, 96'h101, 256'h1, 0, 8'h04);
      op(8'h02, 8'h00, 96'h101, s0, 8, 8'h04);
      op(8'h03, 8'h04, TAG, s0, 0, 8'h04);
      op(8'h05, 8'h00, 96'h101, s0, 0, 8'h04);
      op(8'h03, 8'h00, TAG, s0, 0, 8'h80);
      chk(resp_count, 32'h101);
      chk(resp_tag, TAG);
      chk(resp_valid, 1'b1);
      chk(resp_sig, fh(s0, {TAG, 32'h101}, 8'h80));
      // a foreign opcode must leave the status alone
      ctl.send({~OPC, 8'h01, 304'h0}, 320);
      repeat (10) @(posedge clk_sys);
      #1 chk(ext_status, 8'h80);
      do_reset();
      op(8'h02, 8'h00, 96'h100, s0, 0, 8'h08);
      op(8'h01, 8'h00, KD, s0, 0, 8'h80);
      op(8'h02, 8'h00, 96'h100, s0, 0, 8'h80);
      ctr_init_valid = 4'h0;
      do_reset();
      chk(ext_status, 8'h20);
      summarize();
   end

   // watchdog: about twice the expected run
   initial begin
      #8_000_000;
      errors++;
      $display("[ERR] %0t run did not finish", $time);
      summarize();
   end
endmodule

bind rpc_cmd_top rpc_cmd_assertions #(.NUM_CTR(NUM_CTR), .IDX_W(IDX_W), .OPCODE(OPCODE)) u_chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .hash_req(hash_req), .hash_key(hash_key),
   .hash_msg(hash_msg), .hash_msg_bits(hash_msg_bits), .hash_done(hash_done), .hash_digest(hash_digest),
   .ext_status(ext_status), .resp_valid(resp_valid), .resp_sig(resp_sig));
